/* File: hdl/bdc_clamp.sv */
// Saturates the signed output-voltage code between the clamp bounds.
`timescale 1ns/1ps
`include "bdc_params.svh"
module bdc_clamp (
  input wire logic [`BDC_DATA_W-1:0] code_i,
  input wire logic [3:0] pos_clamp_i,
  input wire logic [3:0] neg_clamp_i,
  output logic [`BDC_DATA_W-1:0] hi_o,
  output logic [`BDC_DATA_W-1:0] lo_o,
  output logic [`BDC_DATA_W-1:0] code_o
);
  logic signed [`BDC_DATA_W-1:0] ext;
  always_comb begin
    ext = {{(`BDC_DATA_W-`BDC_SIGN_BIT-1){code_i[`BDC_SIGN_BIT]}}, code_i[`BDC_SIGN_BIT:0]};
    hi_o = {8'h00, pos_clamp_i, `BDC_POS_LOW};
    lo_o = {`BDC_NEG_BASE, neg_clamp_i, `BDC_NEG_LOW};
    if (ext > $signed(hi_o)) begin
      code_o = hi_o;
    end else if (ext < $signed(lo_o)) begin
      code_o = lo_o;
    end else begin
      code_o = ext;
    end
  end
endmodule // bdc_clamp

/* File: hdl/bdc_ctrl.sv */
// Control and status registers of a full-bridge converter, reached through a word register port.
// Operation
// - Duty range code 00 gives 20-80, 01 gives 15-85, others 10-90 percent.
// - Positive clamp code sets the largest DAC value above twenty ones.
// - Negative clamp code sets the smallest DAC value, stepping 0x100000.
// - Positive current-limit code is nine bits, valid 0 to 462.
// - Negative current-limit code is nine bits, valid 48 to 511.
// - Under current limit at minimum time the driver skips cycles; the code allows skips at minimum time alone, with or without current limit.
// - Pulses shorter than minimum on or off time may be skipped.
// - Interface-supply undervoltage or thermal shutdown triggers an internal reset.
// - Software reset bit starts a device reset.
// - Reset restores register defaults except the status register.
// - Drivers stay disabled while any latched fault is set.
// - Status reports four live active-high indications.
// - Reset-occurred bit sets on every reset until software clears.
// - Six latched fault bits stay set until software clears them.
// - Mux register selects telemetry; enable low tri-states the pin.
// - Test bits shift telemetry output for the selected signal.
// - DAC code is two's complement, sign bit 25 extended upward.
// - Switching needs enable pin and request; faults pull the pin low.
`timescale 1ns/1ps
`include "bdc_params.svh"
module bdc_ctrl (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`BDC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`BDC_DATA_W-1:0] reg_wdata_i,
  output logic [`BDC_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [5:0] fault_evt_i,
  input wire logic current_limit_active_i,
  input wire logic power_limit_active_i,
  input wire logic pwm_switching_i,
  input wire logic min_time_limited_i,
  input wire logic switch_enable_pin_i,
  output logic switch_enable_pin_o,
  output logic switch_enable_pin_oe_o,
  output bdc_pkg::bdc_duty_t duty_range_sel_o,
  output logic [6:0] duty_min_pct_o,
  output logic [6:0] duty_max_pct_o,
  output logic [`BDC_DATA_W-1:0] vout_dac_code_o,
  output logic [8:0] pos_current_limit_code_o,
  output logic [8:0] neg_current_limit_code_o,
  output logic pwm_enable_o,
  output logic linear_enable_o,
  output logic pulse_skip_ok_o,
  output logic [3:0] telemetry_mux_select_o,
  output logic telemetry_out_enable_o,
  output logic [1:0] telemetry_test_shift_o,
  output logic internal_reset_o
);
  import bdc_pkg::*;

  typedef struct packed {
    logic [`BDC_DATA_W-1:0] dac_ff;
    logic [3:0] ovc_ff;
    logic [3:0] uvc_ff;
    logic [8:0] ilimp_ff;
    logic [8:0] ilimn_ff;
    logic [1:0] duty_ff;
    logic switch_enable_request_ff;
    logic [3:0] amux_ff;
    logic telemetry_out_enable_ff;
    logic [1:0] telemetry_test_shift_ff;
    logic [`BDC_ST_W-1:0] status_ff;
    bdc_rst_state_t rs_ff;
    logic [3:0] rs_cnt_ff;
    logic [`BDC_DATA_W-1:0] rdata_ff;
    logic rvalid_ff;
  } bdc_ctrl_st_t;

  bdc_ctrl_st_t st_ff;
  bdc_ctrl_st_t nxt_st;
  logic [3:0] live_s;
  logic [5:0] fault_s;
  logic switch_enable_pin_pin_s;
  logic [`BDC_DATA_W-1:0] clamped;
  logic [`BDC_DATA_W-1:0] hi_bound;
  logic [`BDC_DATA_W-1:0] lo_bound;
  logic any_fault;
  logic soft_rst;
  logic fault_rst;
  logic cfg_rst;

  // Faults and live flags arrive from analog comparators, so they are synchronised.
  bdc_sync2 #(.W(11)) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i({switch_enable_pin_i, fault_evt_i, min_time_limited_i, power_limit_active_i,
      current_limit_active_i, pwm_switching_i}),
    .sync_o({switch_enable_pin_pin_s, fault_s, live_s})
  );

  bdc_clamp u_clamp (
    .code_i(st_ff.dac_ff),
    .pos_clamp_i(st_ff.ovc_ff),
    .neg_clamp_i(st_ff.uvc_ff),
    .hi_o(hi_bound),
    .lo_o(lo_bound),
    .code_o(clamped)
  );

  function automatic logic hit(input logic [`BDC_ADDR_W-1:0] a, input logic [`BDC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid_ff = 1'b0;
    any_fault = |st_ff.status_ff[`BDC_ST_W-1:`BDC_FAULT_LSB];
    soft_rst = reg_wr_i && hit(reg_addr_i, `BDC_OFS_CTRL) && reg_wdata_i[8];
    fault_rst = fault_s[2] | fault_s[1];
    cfg_rst = 1'b0;
    case (st_ff.rs_ff)
      BDC_RS_IDLE: begin
        if (soft_rst || fault_rst) begin
          nxt_st.rs_ff = BDC_RS_HOLD;
          nxt_st.rs_cnt_ff = `BDC_RST_CYC;
        end
      end
      BDC_RS_HOLD: begin
        cfg_rst = 1'b1;
        nxt_st.rs_cnt_ff = st_ff.rs_cnt_ff - 4'h1;
        if (st_ff.rs_cnt_ff == 4'h1) begin
          nxt_st.rs_ff = BDC_RS_DONE;
        end
      end
      BDC_RS_DONE: begin
        nxt_st.rs_ff = BDC_RS_IDLE;
      end
      default: begin
        nxt_st.rs_ff = BDC_RS_IDLE;
      end
    endcase
    if (reg_wr_i && st_ff.rs_ff == BDC_RS_IDLE) begin
      if (hit(reg_addr_i, `BDC_OFS_DAC)) begin
        nxt_st.dac_ff = reg_wdata_i;
      end
      if (hit(reg_addr_i, `BDC_OFS_CLAMP)) begin
        nxt_st.ovc_ff = reg_wdata_i[3:0];
        nxt_st.uvc_ff = reg_wdata_i[7:4];
      end
      if (hit(reg_addr_i, `BDC_OFS_ILIMP)) begin
        nxt_st.ilimp_ff = (reg_wdata_i[8:0] > `BDC_ILIMP_MAX) ? `BDC_ILIMP_MAX : reg_wdata_i[8:0];
      end
      if (hit(reg_addr_i, `BDC_OFS_ILIMN)) begin
        nxt_st.ilimn_ff = (reg_wdata_i[8:0] < `BDC_ILIMN_MIN) ? `BDC_ILIMN_MIN : reg_wdata_i[8:0];
      end
      if (hit(reg_addr_i, `BDC_OFS_CTRL)) begin
        nxt_st.duty_ff = reg_wdata_i[1:0];
        nxt_st.switch_enable_request_ff = reg_wdata_i[4];
      end
      if (hit(reg_addr_i, `BDC_OFS_AMUX)) begin
        nxt_st.amux_ff = reg_wdata_i[3:0];
        nxt_st.telemetry_out_enable_ff = reg_wdata_i[4];
        nxt_st.telemetry_test_shift_ff = reg_wdata_i[6:5];
      end
    end
    if (reg_wr_i && hit(reg_addr_i, `BDC_OFS_STATUS)) begin
      nxt_st.status_ff[`BDC_ST_W-1:`BDC_ST_RESET_BIT] = st_ff.status_ff[`BDC_ST_W-1:`BDC_ST_RESET_BIT] &
        reg_wdata_i[`BDC_ST_W-1:`BDC_ST_RESET_BIT];
    end
    nxt_st.status_ff[3:0] = live_s;
    nxt_st.status_ff[`BDC_ST_W-1:`BDC_FAULT_LSB] = nxt_st.status_ff[`BDC_ST_W-1:`BDC_FAULT_LSB] | fault_s;
    if (st_ff.rs_ff == BDC_RS_DONE) begin
      nxt_st.status_ff[`BDC_ST_RESET_BIT] = 1'b1;
    end
    if (cfg_rst) begin
      nxt_st.dac_ff = `BDC_DAC_RST;
      nxt_st.ovc_ff = `BDC_OVC_RST;
      nxt_st.uvc_ff = `BDC_UVC_RST;
      nxt_st.ilimp_ff = `BDC_ILIMP_RST;
      nxt_st.ilimn_ff = `BDC_ILIMN_RST;
      nxt_st.duty_ff = 2'h0;
      nxt_st.switch_enable_request_ff = 1'b0;
      nxt_st.amux_ff = 4'h0;
      nxt_st.telemetry_out_enable_ff = 1'b0;
      nxt_st.telemetry_test_shift_ff = 2'h0;
    end
    if (reg_rd_i) begin
      nxt_st.rvalid_ff = 1'b1;
      case (reg_addr_i)
        `BDC_OFS_DAC: nxt_st.rdata_ff = st_ff.dac_ff;
        `BDC_OFS_CLAMP: nxt_st.rdata_ff = {24'h0, st_ff.uvc_ff, st_ff.ovc_ff};
        `BDC_OFS_ILIMP: nxt_st.rdata_ff = {23'h0, st_ff.ilimp_ff};
        `BDC_OFS_ILIMN: nxt_st.rdata_ff = {23'h0, st_ff.ilimn_ff};
        `BDC_OFS_CTRL: nxt_st.rdata_ff = {27'h0, st_ff.switch_enable_request_ff, 2'h0, st_ff.duty_ff};
        `BDC_OFS_AMUX: nxt_st.rdata_ff = {25'h0, st_ff.telemetry_test_shift_ff, st_ff.telemetry_out_enable_ff, st_ff.amux_ff};
        `BDC_OFS_STATUS: nxt_st.rdata_ff = {21'h0, st_ff.status_ff};
        default: nxt_st.rdata_ff = 32'h0000_0000;
      endcase
    end
  end

  // The status register is kept across internal resets; only srst_i reloads it, to 0x010 with the reset bit set.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.ovc_ff <= `BDC_OVC_RST;
      st_ff.ilimn_ff <= `BDC_ILIMN_RST;
      st_ff.status_ff <= 11'h010;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    case (st_ff.duty_ff)
      2'h0: begin
        duty_range_sel_o = BDC_DUTY_20_80;
        duty_min_pct_o = 7'h14;
        duty_max_pct_o = 7'h50;
      end
      2'h1: begin
        duty_range_sel_o = BDC_DUTY_15_85;
        duty_min_pct_o = 7'h0F;
        duty_max_pct_o = 7'h55;
      end
      default: begin
        duty_range_sel_o = BDC_DUTY_10_90;
        duty_min_pct_o = 7'h0A;
        duty_max_pct_o = 7'h5A;
      end
    endcase
  end

  assign vout_dac_code_o = clamped;
  assign pos_current_limit_code_o = st_ff.ilimp_ff;
  assign neg_current_limit_code_o = st_ff.ilimn_ff;
  assign linear_enable_o = ~any_fault & (st_ff.rs_ff == BDC_RS_IDLE);
  assign pwm_enable_o = linear_enable_o & st_ff.switch_enable_request_ff & switch_enable_pin_pin_s;
  assign switch_enable_pin_o = 1'b0;
  assign switch_enable_pin_oe_o = any_fault;
  // Skip whenever at minimum time, with or without current limit.
  assign pulse_skip_ok_o = st_ff.status_ff[3] | (st_ff.status_ff[1] & st_ff.status_ff[3]);
  assign telemetry_mux_select_o = st_ff.amux_ff;
  assign telemetry_out_enable_o = st_ff.telemetry_out_enable_ff;
  assign telemetry_test_shift_o = st_ff.telemetry_test_shift_ff;
  assign internal_reset_o = (st_ff.rs_ff == BDC_RS_HOLD);
  assign reg_rdata_o = st_ff.rdata_ff;
  assign reg_rvalid_o = st_ff.rvalid_ff;
endmodule // bdc_ctrl

/* File: hdl/bdc_params.svh */
// Constants for the bridge driver control and status block.
`ifndef BDC_PARAMS_SVH
`define BDC_PARAMS_SVH
`define BDC_DATA_W 32
`define BDC_ADDR_W 4
`define BDC_OFS_DAC 4'h0
`define BDC_OFS_CLAMP 4'h1
`define BDC_OFS_ILIMP 4'h2
`define BDC_OFS_ILIMN 4'h3
`define BDC_OFS_CTRL 4'h4
`define BDC_OFS_AMUX 4'h5
`define BDC_OFS_STATUS 4'h6
`define BDC_DAC_RST 32'h0000_0000
`define BDC_OVC_RST 4'hF
`define BDC_UVC_RST 4'h0
`define BDC_ILIMP_RST 9'h000
`define BDC_ILIMN_RST 9'h1FF
`define BDC_ILIMP_MAX 9'h1CE
`define BDC_ILIMN_MIN 9'h030
`define BDC_POS_LOW 20'hFFFFF
`define BDC_NEG_BASE 8'hFF
`define BDC_NEG_LOW 20'h00000
`define BDC_SIGN_BIT 25
`define BDC_ST_W 11
`define BDC_FAULT_LSB 5
`define BDC_ST_RESET_BIT 4
`define BDC_MIN_TIME_NS 50
`define BDC_CLK_NS 5
`define BDC_MIN_CYC ((`BDC_MIN_TIME_NS + `BDC_CLK_NS - 1) / `BDC_CLK_NS)
`define BDC_RST_CYC 4'h4
`endif

/* File: hdl/bdc_pkg.sv */
// Types shared by the bridge driver control and status block.
package bdc_pkg;
  typedef enum logic [1:0] {
    BDC_DUTY_20_80 = 2'h0,
    BDC_DUTY_15_85 = 2'h1,
    BDC_DUTY_10_90 = 2'h2
  } bdc_duty_t;
  typedef enum logic [1:0] {
    BDC_RS_IDLE = 2'h0,
    BDC_RS_HOLD = 2'h1,
    BDC_RS_DONE = 2'h3
  } bdc_rst_state_t;
endpackage

/* File: hdl/bdc_sync2.sv */
// Two-flop synchroniser for pin-level inputs.
`timescale 1ns/1ps
module bdc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
  } bdc_sync_st_t;
  bdc_sync_st_t st_ff;
  bdc_sync_st_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta_ff = async_i;
    nxt_st.sync_ff = st_ff.meta_ff;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sync_o = st_ff.sync_ff;
endmodule // bdc_sync2

/* File: verification/bdc_ctrl_monitor.sv */
// Port checker for the bridge driver control block.
`timescale 1ns/1ps
module bdc_ctrl_monitor (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic switch_enable_pin_o,
  input wire logic switch_enable_pin_oe_o,
  input wire bdc_pkg::bdc_duty_t duty_range_sel_o,
  input wire logic [6:0] duty_min_pct_o,
  input wire logic [6:0] duty_max_pct_o,
  input wire logic [31:0] vout_dac_code_o,
  input wire logic [8:0] pos_current_limit_code_o,
  input wire logic [8:0] neg_current_limit_code_o,
  input wire logic pwm_enable_o,
  input wire logic linear_enable_o,
  input wire logic internal_reset_o
);
  import bdc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_duty; duty_min_pct_o == (duty_range_sel_o == BDC_DUTY_20_80 ? 7'h14 :
    duty_range_sel_o == BDC_DUTY_15_85 ? 7'h0F : 7'h0A) && duty_max_pct_o == 7'h64 - duty_min_pct_o; endproperty
  a_duty: assert property (p_duty) else $error("duty span wrong");
  property p_sign; vout_dac_code_o[31:25] == {7{vout_dac_code_o[25]}}; endproperty
  a_sign: assert property (p_sign) else $error("code not sign extended");
  property p_bound; $signed(vout_dac_code_o) <= 32'sh00FFFFFF && $signed(vout_dac_code_o) >= 32'shFF000000; endproperty
  a_bound: assert property (p_bound) else $error("code beyond clamp range");
  // Writes are also dropped in the cycle right after the hold, so that cycle is left out.
  property p_ilimp; reg_wr_i && reg_addr_i == 4'h2 && reg_wdata_i[8:0] > 9'h1CE && !internal_reset_o &&
    !$past(internal_reset_o) |=> pos_current_limit_code_o == 9'h1CE; endproperty
  a_ilimp: assert property (p_ilimp) else $error("positive limit not saturated");
  property p_ilimn; neg_current_limit_code_o >= 9'h030; endproperty
  a_ilimn: assert property (p_ilimn) else $error("negative limit below range");
  property p_flt; switch_enable_pin_oe_o |-> !pwm_enable_o && !linear_enable_o; endproperty
  a_flt: assert property (p_flt) else $error("driver on with fault");
  property p_pin; !switch_enable_pin_o; endproperty
  a_pin: assert property (p_pin) else $error("enable pin driven high");
  property p_pwm; pwm_enable_o |-> linear_enable_o; endproperty
  a_pwm: assert property (p_pwm) else $error("switching while blocked");
  property p_hold; $rose(internal_reset_o) |-> (internal_reset_o && !linear_enable_o) [*4]; endproperty
  a_hold: assert property (p_hold) else $error("reset hold too short");
  property p_soft; reg_wr_i && reg_addr_i == 4'h4 && reg_wdata_i[8] && !internal_reset_o &&
    !$past(internal_reset_o) |-> ##[1:4] internal_reset_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset not started");
endmodule // bdc_ctrl_monitor

/* File: verification/bdc_mcu_model.sv */
// Register master and enable pin pull-up standing in for the controller.
`timescale 1ns/1ps
module bdc_mcu_model (
  input wire logic clk_sys_i,
  input wire logic pin_oe_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [3:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic pin_o
);
  logic ext_low;
  assign pin_o = !(pin_oe_i || ext_low);
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o, ext_low} = '0;
  end
  // Data is inverted on release so a stale word is never mistaken for a fresh one.
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    reg_wr_o = w;
    reg_rd_o = !w;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
endmodule // bdc_mcu_model

/* File: verification/bridge_driver_control_status_tb_top.sv */
// Self-checking bench for the bridge driver control block.
`timescale 1ns/1ps
module bridge_driver_control_status_tb_top;
  import bdc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, switch_enable_pin_i, switch_enable_pin_o, switch_enable_pin_oe_o;
  logic pwm_enable_o, linear_enable_o, pulse_skip_ok_o, telemetry_out_enable_o, internal_reset_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, vout_dac_code_o, d, e, hi, lo, se;
  logic [8:0] pos_current_limit_code_o, neg_current_limit_code_o;
  logic [6:0] duty_min_pct_o, duty_max_pct_o;
  logic [5:0] fault_evt_i;
  logic [3:0] reg_addr_i, telemetry_mux_select_o, live, p, n;
  logic [1:0] telemetry_test_shift_o;
  bdc_duty_t duty_range_sel_o;
  wire logic pwm_switching_i, current_limit_active_i, power_limit_active_i, min_time_limited_i;
  logic [31:0] exp_q[$];
  int n_errors = 0, num_checks = 0, cycles = 0;
  assign {min_time_limited_i, power_limit_active_i, current_limit_active_i, pwm_switching_i} = live;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bdc_ctrl uut (.*);
  bdc_mcu_model m (.clk_sys_i(clk_sys_i), .pin_oe_i(switch_enable_pin_oe_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .pin_o(switch_enable_pin_i));
  task automatic chk(input logic [31:0] act, input logic [31:0] ex);
    num_checks++;
    if (act !== ex) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, act, ex);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    m.acc(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic complete_run;
    // A read that never answered leaves its note behind and must not pass silently.
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("MISMATCH at %0t: %0d reads never answered", $time, exp_q.size());
    end
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(negedge clk_sys_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(reg_rdata_o, exp_q.pop_front());
      end else begin
        n_errors++;
        $display("MISMATCH at %0t: read answer with no expectation", $time);
      end
    end
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(94));
    srst_i = 1'b1;
    fault_evt_i = 6'h00;
    live = 4'h0;
    cyc(5);
    srst_i = 1'b0;
    rd(4'h6, 32'h10);
    rd(4'h3, 32'h1FF);
    rd(4'hA, 32'h0);
    for (int i = 0; i < 4; i++) begin
      m.acc(1'b1, 4'h4, 32'(i));
      chk(32'({duty_min_pct_o, duty_max_pct_o}), i == 0 ? 32'hA50 : i == 1 ? 32'h7D5 : 32'h55A);
      chk(32'(duty_range_sel_o), 32'(i == 0 ? BDC_DUTY_20_80 : i == 1 ? BDC_DUTY_15_85 : BDC_DUTY_10_90));
    end
    for (int i = 0; i < 20; i++) begin
      p = 4'($urandom);
      n = 4'($urandom);
      d = $urandom;
      if (i[0]) d = {{12{d[19]}}, d[19:0]};
      hi = {8'h00, p, 20'hFFFFF};
      lo = {8'hFF, n, 20'h00000};
      se = {{6{d[25]}}, d[25:0]};
      m.acc(1'b1, 4'h1, {24'h0, n, p});
      m.acc(1'b1, 4'h0, d);
      chk(vout_dac_code_o, $signed(se) > $signed(hi) ? hi : $signed(se) < $signed(lo) ? lo : se);
    end
    for (int i = 0; i < 4; i++) begin
      d = i[1] ? (i[0] ? 32'h0A : 32'h1FF) : (i[0] ? 32'h1F4 : 32'h1CE);
      e = i[1] ? (i[0] ? 32'h30 : 32'h1FF) : 32'h1CE;
      m.acc(1'b1, i[1] ? 4'h3 : 4'h2, d);
      rd(i[1] ? 4'h3 : 4'h2, e);
      chk(32'(i[1] ? neg_current_limit_code_o : pos_current_limit_code_o), e);
    end
    m.acc(1'b1, 4'h6, 32'h0);
    m.acc(1'b1, 4'h4, 32'h100);
    cyc(12);
    rd(4'h2, 32'h0);
    rd(4'h1, 32'h0F);
    rd(4'h6, 32'h10);
    for (int i = 0; i < 6; i++) begin
      m.acc(1'b1, 4'h6, 32'h0);
      fault_evt_i = 6'h01 << i;
      cyc(3);
      fault_evt_i = 6'h00;
      cyc(16);
      chk(32'({switch_enable_pin_oe_o, linear_enable_o, pwm_enable_o}), 32'h4);
      m.acc(1'b1, 4'h6, 32'h7F0);
      rd(4'h6, (32'h20 << i) | ((i == 1 || i == 2) ? 32'h10 : 32'h0));
    end
    m.acc(1'b1, 4'h6, 32'h0);
    rd(4'h6, 32'h0);
    m.acc(1'b1, 4'h4, 32'h10);
    cyc(4);
    chk(32'({linear_enable_o, pwm_enable_o}), 32'h3);
    m.ext_low = 1'b1;
    cyc(4);
    chk(32'({linear_enable_o, pwm_enable_o}), 32'h2);
    m.ext_low = 1'b0;
    rd(4'h4, 32'h10);
    for (int i = 0; i < 4; i++) begin
      live = 4'($urandom);
      cyc(4);
      rd(4'h6, 32'(live));
      chk(32'(pulse_skip_ok_o), 32'(live[3]));
      d = $urandom & 32'h7F;
      m.acc(1'b1, 4'h5, d);
      rd(4'h5, d);
      chk(32'({telemetry_test_shift_o, telemetry_out_enable_o, telemetry_mux_select_o}), d);
    end
    cyc(4);
    complete_run();
  end
endmodule // bridge_driver_control_status_tb_top
bind bdc_ctrl bdc_ctrl_monitor u_mon (.*);
